/* File: rtl/ccl_clock_ctrl.sv */
// clock synthesizer control: post-divider, loss-of-clock reset, stop mode sequencing
// assumes all inputs synchronous to pclk; pclk stands for the pll output
// Function
// - post-divider code divides by two to the code plus one
// - divider change leaves pll and lock untouched
// - new divider applies at system clock falling edge
// - loss reset enable ignored without detect enable
// - clock loss with enable resets immediately
// - external clock mode ignores loss reset enable
// - pll and osc off, no fast wakeup: self-clocked, then relock, then normal; fast wakeup goes straight to normal
// - pll off, osc on, no fast wakeup: wait relock, no reference; fast wakeup goes straight to normal
// - multiplier code gives four to eighteen times
//
// The register addresses and the APB slave port were left to the implementer.
module ccl_clock_ctrl #(
  parameter int ADDR_W = ccl_pkg::CCL_ADDR_W
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // pll and system status
  input  wire ccl_pkg::ccl_clk_in_type clk_in,
  input  wire ccl_pkg::ccl_sys_in_type sys_in,
  // clock module outputs
  output logic                       sysclk,
  output logic      [4:0]            mult_factor,
  output logic                       pll_enable,
  output logic                       osc_enable,
  output logic                       sys_reset_req,
  output logic      [2:0]            mode,
  output logic                       irq
);
  import ccl_pkg::*;

  ccl_ctrl_type           ctrl_ff, nxt_ctrl;
  ccl_mode_type           state_ff, nxt_state;
  logic [CCL_INT_W-1:0]   int_stat_ff, nxt_int_stat;
  logic [CCL_INT_W-1:0]   int_en_ff, nxt_int_en;
  logic [31:0]            prdata_ff, nxt_prdata;
  logic                   pready_ff, nxt_pready;
  logic                   pslverr_ff, nxt_pslverr;
  logic                   irq_ff, nxt_irq;
  logic [2:0]             active_div_ff, nxt_active_div;
  logic [6:0]             cnt_ff, nxt_cnt;
  logic                   sysclk_ff, nxt_sysclk;
  logic                   lock_ff, nxt_lock;
  logic                   sticky_ff, nxt_sticky;
  logic                   lost_ff, nxt_lost;
  logic                   lost_ref_ff, nxt_lost_ref;
  logic                   lost_fb_ff, nxt_lost_fb;
  logic                   pll_off_ff, nxt_pll_off;
  logic                   osc_off_ff, nxt_osc_off;
  logic                   rst_ff, nxt_rst;
  logic [4:0]             mult_ff, nxt_mult;
  logic                   pll_en_ff, nxt_pll_en;
  logic                   osc_en_ff, nxt_osc_en;

  logic                   acc, wr_ctrl, wr_clr, wr_en, mapped;
  logic                   loss_rst_eff, loss_now, lock_fall;
  logic [6:0]             half_m1;
  logic [CCL_INT_W-1:0]   ev;

  // apb slave: answer registered in setup, so access completes with no wait state
  always_comb begin
    acc      = psel && penable && pready_ff;
    mapped   = (paddr == CCL_CTRL_OFF) || (paddr == CCL_STAT_OFF) ||
               (paddr == CCL_INT_STAT_OFF) || (paddr == CCL_INT_CLR_OFF) ||
               (paddr == CCL_INT_EN_OFF);
    wr_ctrl  = acc && pwrite && (paddr == CCL_CTRL_OFF);
    wr_clr   = acc && pwrite && (paddr == CCL_INT_CLR_OFF);
    wr_en    = acc && pwrite && (paddr == CCL_INT_EN_OFF);
    nxt_pready  = psel && !penable;
    nxt_pslverr = psel && !penable && !mapped;
    nxt_prdata  = 32'h0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        CCL_CTRL_OFF: begin
          nxt_prdata[CCL_MULT_LSB +: 3]     = ctrl_ff.feedback_multiplier;
          nxt_prdata[CCL_LOSS_RST_BIT]      = ctrl_ff.clock_loss_reset_en;
          nxt_prdata[CCL_DIV_LSB +: 3]      = ctrl_ff.sysclk_post_divider;
          nxt_prdata[CCL_DETECT_BIT]        = ctrl_ff.clock_loss_detect_en;
          nxt_prdata[CCL_SETTLE_RST_BIT]    = ctrl_ff.settle_loss_reset_en;
        end
        CCL_STAT_OFF: begin
          nxt_prdata[CCL_LOCK_BIT]          = lock_ff;
          nxt_prdata[CCL_STICKY_BIT]        = sticky_ff;
          nxt_prdata[CCL_LOST_BIT]          = lost_ff;
          nxt_prdata[CCL_MODE_LSB +: 3]     = state_ff;
        end
        CCL_INT_STAT_OFF: nxt_prdata[CCL_INT_W-1:0] = int_stat_ff;
        CCL_INT_EN_OFF:   nxt_prdata[CCL_INT_W-1:0] = int_en_ff;
        default:          nxt_prdata = 32'h0;
      endcase
    end
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl.feedback_multiplier  = pwdata[CCL_MULT_LSB +: 3];
      nxt_ctrl.clock_loss_reset_en  = pwdata[CCL_LOSS_RST_BIT];
      nxt_ctrl.sysclk_post_divider  = pwdata[CCL_DIV_LSB +: 3];
      nxt_ctrl.clock_loss_detect_en = pwdata[CCL_DETECT_BIT];
      nxt_ctrl.settle_loss_reset_en = pwdata[CCL_SETTLE_RST_BIT];
    end
    nxt_int_en = wr_en ? pwdata[CCL_INT_W-1:0] : int_en_ff;
  end

  // post-divider: half period of 2**code pll cycles, divider swapped at falling edge
  always_comb begin
    half_m1        = 7'((8'h01 << active_div_ff) - 8'h01);
    nxt_cnt        = cnt_ff + 7'h01;
    nxt_sysclk     = sysclk_ff;
    nxt_active_div = active_div_ff;
    if (cnt_ff >= half_m1) begin
      nxt_cnt    = 7'h00;
      nxt_sysclk = !sysclk_ff;
      if (sysclk_ff) begin
        nxt_active_div = ctrl_ff.sysclk_post_divider;
      end
    end
  end

  // mode sequencing across stop, lock and clock-loss tracking
  always_comb begin
    nxt_state    = state_ff;
    nxt_lost_ref = lost_ref_ff;
    nxt_lost_fb  = lost_fb_ff;
    nxt_pll_off  = pll_off_ff;
    nxt_osc_off  = osc_off_ff;
    nxt_sticky   = sticky_ff;
    loss_now     = 1'b0;
    unique case (state_ff)
      CCL_NORMAL_PLL_MODE: begin
        loss_now = ctrl_ff.clock_loss_detect_en && (!clk_in.ref_ok || !clk_in.fb_ok);
        if (sys_in.stop_req) begin
          nxt_state    = CCL_STOP_MODE;
          nxt_pll_off  = sys_in.stop_pll_off;
          nxt_osc_off  = sys_in.stop_osc_off;
          nxt_lost_ref = 1'b0;
          nxt_lost_fb  = 1'b0;
        end
      end
      CCL_STOP_MODE: begin
        if (!osc_off_ff && !clk_in.ref_ok) nxt_lost_ref = 1'b1;
        if (!pll_off_ff && !clk_in.fb_ok)  nxt_lost_fb  = 1'b1;
        if (!sys_in.stop_req) begin
          if (lost_ref_ff) begin
            nxt_state  = CCL_SELF_CLOCKED_MODE;
            loss_now   = 1'b1;
            nxt_sticky = 1'b0;
          end else if (lost_fb_ff) begin
            nxt_state  = CCL_REFERENCE_MODE;
            loss_now   = 1'b1;
            nxt_sticky = 1'b0;
          end else if (pll_off_ff && sys_in.fast_wakeup) begin
            nxt_state  = CCL_NORMAL_PLL_MODE;
          end else if (pll_off_ff && osc_off_ff) begin
            nxt_state  = CCL_SELF_CLOCKED_MODE;
          end else if (pll_off_ff) begin
            nxt_state  = CCL_RELOCK_MODE;
          end else begin
            nxt_state  = CCL_NORMAL_PLL_MODE;
          end
        end
      end
      CCL_SELF_CLOCKED_MODE: begin
        if (clk_in.ref_ok) nxt_state = CCL_RELOCK_MODE;
      end
      CCL_REFERENCE_MODE, CCL_RELOCK_MODE: begin
        if (clk_in.fb_ok && clk_in.pll_locked) nxt_state = CCL_NORMAL_PLL_MODE;
      end
      default: nxt_state = CCL_NORMAL_PLL_MODE;
    endcase
    nxt_lock = clk_in.pll_locked && (nxt_state != CCL_SELF_CLOCKED_MODE) &&
               !(nxt_state == CCL_STOP_MODE && nxt_pll_off);
    lock_fall = lock_ff && !nxt_lock;
    if (lock_fall) nxt_sticky = 1'b0;
    if (nxt_lock && !lock_ff && nxt_state == CCL_NORMAL_PLL_MODE) nxt_sticky = 1'b1;
    // a new loss wins over a clearing write
    nxt_lost = lost_ff;
    if (wr_ctrl && !pwdata[CCL_DETECT_BIT]) nxt_lost = 1'b0;
    if (loss_now) nxt_lost = 1'b1;
    loss_rst_eff = ctrl_ff.clock_loss_detect_en && ctrl_ff.clock_loss_reset_en &&
                   !sys_in.ext_mode;
    nxt_rst = (loss_rst_eff && (nxt_lost ||
               (state_ff == CCL_STOP_MODE && pll_off_ff))) ||
              (ctrl_ff.settle_loss_reset_en && lock_fall &&
               state_ff == CCL_NORMAL_PLL_MODE);
    nxt_pll_en = !(nxt_state == CCL_STOP_MODE && nxt_pll_off);
    nxt_osc_en = !(nxt_state == CCL_STOP_MODE && nxt_osc_off);
    if (sys_in.ext_mode || sys_in.one_to_one) begin
      nxt_mult = CCL_MULT_BYPASS;
    end else begin
      nxt_mult = 5'({1'b0, ctrl_ff.feedback_multiplier, 1'b0}) + CCL_MULT_BASE;
    end
  end

  // sticky interrupt status, set wins over clear
  always_comb begin
    ev                    = '0;
    ev[CCL_EV_LOCK_LOST]  = lock_fall;
    ev[CCL_EV_CLOCK_LOST] = loss_now && !lost_ff;
    ev[CCL_EV_LOCK_GAIN]  = nxt_lock && !lock_ff;
    nxt_int_stat = int_stat_ff;
    if (wr_clr) nxt_int_stat = int_stat_ff & ~pwdata[CCL_INT_W-1:0];
    nxt_int_stat = nxt_int_stat | ev;
    nxt_irq      = |(nxt_int_stat & nxt_int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff       <= CCL_CTRL_RST;
      state_ff      <= CCL_NORMAL_PLL_MODE;
      int_stat_ff   <= '0;
      int_en_ff     <= '0;
      prdata_ff     <= 32'h0;
      pready_ff     <= 1'b0;
      pslverr_ff    <= 1'b0;
      irq_ff        <= 1'b0;
      active_div_ff <= CCL_DIV_RST;
      cnt_ff        <= 7'h00;
      sysclk_ff     <= 1'b0;
      lock_ff       <= 1'b0;
      sticky_ff     <= 1'b0;
      lost_ff       <= 1'b0;
      lost_ref_ff   <= 1'b0;
      lost_fb_ff    <= 1'b0;
      pll_off_ff    <= 1'b0;
      osc_off_ff    <= 1'b0;
      rst_ff        <= 1'b0;
      mult_ff       <= CCL_MULT_BYPASS;
      pll_en_ff     <= 1'b1;
      osc_en_ff     <= 1'b1;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      state_ff      <= nxt_state;
      int_stat_ff   <= nxt_int_stat;
      int_en_ff     <= nxt_int_en;
      prdata_ff     <= nxt_prdata;
      pready_ff     <= nxt_pready;
      pslverr_ff    <= nxt_pslverr;
      irq_ff        <= nxt_irq;
      active_div_ff <= nxt_active_div;
      cnt_ff        <= nxt_cnt;
      sysclk_ff     <= nxt_sysclk;
      lock_ff       <= nxt_lock;
      sticky_ff     <= nxt_sticky;
      lost_ff       <= nxt_lost;
      lost_ref_ff   <= nxt_lost_ref;
      lost_fb_ff    <= nxt_lost_fb;
      pll_off_ff    <= nxt_pll_off;
      osc_off_ff    <= nxt_osc_off;
      rst_ff        <= nxt_rst;
      mult_ff       <= nxt_mult;
      pll_en_ff     <= nxt_pll_en;
      osc_en_ff     <= nxt_osc_en;
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign sysclk        = sysclk_ff;
  assign mult_factor   = mult_ff;
  assign pll_enable    = pll_en_ff;
  assign osc_enable    = osc_en_ff;
  assign sys_reset_req = rst_ff;
  assign mode          = state_ff;
  assign irq           = irq_ff;

  // helper: cycles the system clock has been high
  logic [7:0] hi_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_ff <= 8'h00;
    end else begin
      hi_cnt_ff <= sysclk_ff ? hi_cnt_ff + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop_wake;
    state_ff == CCL_STOP_MODE && !sys_in.stop_req;
  endsequence
  sequence s_clean_pll_off;
    pll_off_ff && !lost_ref_ff && !lost_fb_ff && !sys_in.fast_wakeup;
  endsequence

  a_div_high_len: assert property ($fell(sysclk_ff) |->
    $past(hi_cnt_ff) + 8'h01 == (8'h01 << $past(active_div_ff)))
    else $error("system clock high phase does not match divider");
  a_div_keeps_lock: assert property (wr_ctrl && lock_ff && clk_in.pll_locked &&
    state_ff == CCL_NORMAL_PLL_MODE && !sys_in.stop_req |=> lock_ff)
    else $error("divider write disturbed lock");
  a_div_at_fall: assert property ($changed(active_div_ff) |-> $fell(sysclk_ff))
    else $error("divider changed outside a falling edge");
  a_loss_gated: assert property (!ctrl_ff.clock_loss_detect_en &&
    !ctrl_ff.settle_loss_reset_en |=> !sys_reset_req)
    else $error("loss reset without detect enable");
  // a write that clears the flag in the same cycle ends the loss condition
  a_loss_reset_now: assert property (loss_rst_eff && lost_ff &&
    !(wr_ctrl && !pwdata[CCL_DETECT_BIT]) |=> sys_reset_req)
    else $error("clock loss did not reset");
  a_pll_off_stop_rst: assert property (loss_rst_eff && state_ff == CCL_STOP_MODE &&
    pll_off_ff |=> sys_reset_req)
    else $error("pll-off stop with loss reset did not reset");
  a_ext_no_reset: assert property (sys_in.ext_mode && !ctrl_ff.settle_loss_reset_en
    |=> !sys_reset_req)
    else $error("loss reset in external clock mode");
  a_both_off_wake: assert property (s_stop_wake ##0 s_clean_pll_off ##0 osc_off_ff
    |=> state_ff == CCL_SELF_CLOCKED_MODE)
    else $error("pll and osc off wake not self-clocked");
  a_scm_to_relock: assert property (state_ff == CCL_SELF_CLOCKED_MODE &&
    clk_in.ref_ok |=> state_ff == CCL_RELOCK_MODE ##1 (state_ff != CCL_REFERENCE_MODE))
    else $error("self-clocked mode did not leave on reference");
  a_pll_off_wake: assert property (s_stop_wake ##0 s_clean_pll_off ##0 !osc_off_ff
    |=> state_ff == CCL_RELOCK_MODE)
    else $error("pll off wake entered wrong mode");
  a_relock_done: assert property (state_ff == CCL_RELOCK_MODE && clk_in.fb_ok &&
    clk_in.pll_locked |=> state_ff == CCL_NORMAL_PLL_MODE)
    else $error("relock did not return to normal mode");
  a_mult_value: assert property (!sys_in.ext_mode && !sys_in.one_to_one &&
    ctrl_ff.feedback_multiplier == 3'h7 |=> mult_factor == 5'h12)
    else $error("multiplier code seven not eighteen");
  a_wake_ref_lost: assert property (s_stop_wake ##0 lost_ref_ff |=>
    state_ff == CCL_SELF_CLOCKED_MODE && lost_ff && !lock_ff && !sticky_ff)
    else $error("reference loss in stop woke wrongly");
  a_wake_fb_lost: assert property (s_stop_wake ##0 !lost_ref_ff ##0 lost_fb_ff |=>
    state_ff == CCL_REFERENCE_MODE && lost_ff && !sticky_ff)
    else $error("feedback loss in stop woke wrongly");
endmodule

/* File: rtl/ccl_pkg.sv */
// constants, field layouts and carrier types of the clock synthesizer control block
// assumes a single pclk domain and an APB slave with 32-bit data
package ccl_pkg;
  localparam int          CCL_ADDR_W       = 12;
  localparam logic [11:0] CCL_CTRL_OFF     = 12'h000;
  localparam logic [11:0] CCL_STAT_OFF     = 12'h004;
  localparam logic [11:0] CCL_INT_STAT_OFF = 12'h008;
  localparam logic [11:0] CCL_INT_CLR_OFF  = 12'h00c;
  localparam logic [11:0] CCL_INT_EN_OFF   = 12'h010;

  // control register field positions
  localparam int CCL_MULT_LSB       = 12;
  localparam int CCL_LOSS_RST_BIT   = 11;
  localparam int CCL_DIV_LSB        = 8;
  localparam int CCL_DETECT_BIT     = 7;
  localparam int CCL_SETTLE_RST_BIT = 6;
  // status register field positions
  localparam int CCL_LOCK_BIT       = 0;
  localparam int CCL_STICKY_BIT     = 1;
  localparam int CCL_LOST_BIT       = 2;
  localparam int CCL_MODE_LSB       = 4;

  localparam logic [2:0] CCL_MULT_RST = 3'h2;
  localparam logic [2:0] CCL_DIV_RST  = 3'h1;
  localparam logic [4:0] CCL_MULT_BASE   = 5'h04;
  localparam logic [4:0] CCL_MULT_BYPASS = 5'h01;

  // interrupt event bits
  localparam int CCL_INT_W         = 3;
  localparam int CCL_EV_LOCK_LOST  = 0;
  localparam int CCL_EV_CLOCK_LOST = 1;
  localparam int CCL_EV_LOCK_GAIN  = 2;

  typedef enum logic [2:0] {
    CCL_NORMAL_PLL_MODE   = 3'b000,
    CCL_REFERENCE_MODE    = 3'b001,
    CCL_SELF_CLOCKED_MODE = 3'b010,
    CCL_STOP_MODE         = 3'b011,
    CCL_RELOCK_MODE       = 3'b100
  } ccl_mode_type;

  typedef struct packed {
    logic [2:0] feedback_multiplier;
    logic       clock_loss_reset_en;
    logic [2:0] sysclk_post_divider;
    logic       clock_loss_detect_en;
    logic       settle_loss_reset_en;
  } ccl_ctrl_type;

  localparam ccl_ctrl_type CCL_CTRL_RST = '{CCL_MULT_RST, 1'b0, CCL_DIV_RST, 1'b0, 1'b0};

  // analog side status, synchronous to pclk
  typedef struct packed {
    logic ref_ok;
    logic fb_ok;
    logic pll_locked;
  } ccl_clk_in_type;

  // chip level mode and stop request
  typedef struct packed {
    logic ext_mode;
    logic one_to_one;
    logic stop_req;
    logic stop_pll_off;
    logic stop_osc_off;
    logic fast_wakeup;
  } ccl_sys_in_type;
endpackage

/* File: verif/tb.sv */
// self-checking bench for the clock synthesizer control block
// assumes ccl_pkg is compiled first; the bench drives apb, clock status and system inputs
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ccl_pkg::*;

  logic           pclk        = 1'b0;
  logic           presetn     = 1'b0;
  logic [11:0]    paddr       = 12'h000;
  logic           psel        = 1'b0;
  logic           penable     = 1'b0;
  logic           pwrite      = 1'b0;
  logic [31:0]    pwdata      = 32'h0;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  ccl_clk_in_type clk_in      = 3'b110;
  ccl_sys_in_type sys_in      = 6'h00;
  logic           sysclk;
  logic [4:0]     mult_factor;
  logic           pll_enable;
  logic           osc_enable;
  logic           sys_reset_req;
  logic [2:0]     mode;
  logic           irq;
  logic [31:0]    rdv;
  logic           errv;
  int             n_mismatch  = 0;
  int             check_count = 0;
  int             cyc         = 0;

  always #4 pclk = ~pclk;

  ccl_clock_ctrl uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_in(clk_in), .sys_in(sys_in), .sysclk(sysclk), .mult_factor(mult_factor),
    .pll_enable(pll_enable), .osc_enable(osc_enable), .sys_reset_req(sys_reset_req),
    .mode(mode), .irq(irq)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv     = prdata;
    errv    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_in(input logic [2:0] c, input logic [5:0] s);
    @(posedge pclk);
    clk_in <= c;
    sys_in <= s;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic wait_rise();
    do @(negedge pclk); while (sysclk !== 1'b0);
    do @(negedge pclk); while (sysclk !== 1'b1);
  endtask

  task automatic count_hi(output int n);
    n = 0;
    do begin
      n++;
      @(negedge pclk);
    end while (sysclk === 1'b1);
  endtask

  task automatic t_regs();
    apb(1'b0, CCL_CTRL_OFF, 32'h0);
    `CHK("ctrl reset", 32'h0000_2100, rdv)
    `CHK("mult reset", 5'h08, mult_factor)
    set_in(3'b111, 6'h00);
    settle(2);
    apb(1'b0, CCL_STAT_OFF, 32'h0);
    `CHK("stat locked", 32'h0000_0003, rdv)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped err", 1'b1, errv)
  endtask

  task automatic t_mult();
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, CCL_CTRL_OFF, 32'h100 | (32'(c) << 12));
      settle(1);
      `CHK("mult factor", 5'(2 * c + 4), mult_factor)
    end
    set_in(3'b111, 6'b010000);
    settle(1);
    `CHK("mult one to one", 5'h01, mult_factor)
    set_in(3'b111, 6'b100000);
    settle(1);
    `CHK("mult external", 5'h01, mult_factor)
    set_in(3'b111, 6'h00);
  endtask

  task automatic t_div();
    int n;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, CCL_CTRL_OFF, 32'h2000 | (32'(c) << 8));
      wait_rise();
      count_hi(n);
      wait_rise();
      count_hi(n);
      `CHK("high phase", 2 ** c, n)
      `CHK("pll kept on", 1'b1, pll_enable)
    end
    apb(1'b0, CCL_STAT_OFF, 32'h0);
    `CHK("lock kept", 32'h0000_0003, rdv)
    apb(1'b1, CCL_CTRL_OFF, 32'h2300);
    wait_rise();
    wait_rise();
    fork
      apb(1'b1, CCL_CTRL_OFF, 32'h2000);
      count_hi(n);
    join
    `CHK("old phase kept", 8, n)
    wait_rise();
    count_hi(n);
    `CHK("new phase", 1, n)
  endtask

  task automatic t_loss();
    apb(1'b1, CCL_INT_CLR_OFF, 32'h7);
    apb(1'b1, CCL_CTRL_OFF, 32'h2900);
    set_in(3'b011, 6'h00);
    settle(3);
    `CHK("reset detect off", 1'b0, sys_reset_req)
    set_in(3'b011, 6'b100000);
    apb(1'b1, CCL_CTRL_OFF, 32'h2980);
    settle(3);
    `CHK("reset external", 1'b0, sys_reset_req)
    set_in(3'b011, 6'h00);
    settle(0);
    `CHK("reset not early", 1'b0, sys_reset_req)
    settle(1);
    `CHK("reset asserted", 1'b1, sys_reset_req)
    apb(1'b0, CCL_INT_STAT_OFF, 32'h0);
    `CHK("int stat lost", 32'h0000_0002, rdv)
    apb(1'b1, CCL_INT_EN_OFF, 32'h2);
    settle(1);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, CCL_INT_EN_OFF, 32'h0);
    settle(1);
    `CHK("irq masked", 1'b0, irq)
    set_in(3'b111, 6'h00);
    apb(1'b1, CCL_CTRL_OFF, 32'h2100);
    settle(1);
    `CHK("reset released", 1'b0, sys_reset_req)
    apb(1'b1, CCL_INT_CLR_OFF, 32'h2);
    apb(1'b1, CCL_INT_EN_OFF, 32'h2);
    settle(1);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b0, CCL_INT_CLR_OFF, 32'h0);
    `CHK("clear reads zero", 32'h0, rdv)
  endtask

  // stop entry and exit with the given clock status held during stop and at wake
  task automatic stop_case(input logic [5:0] s, input logic [2:0] c, input logic [2:0] m,
                           input logic [31:0] st, input logic [2:0] m2);
    apb(1'b1, CCL_CTRL_OFF, 32'h2180);
    set_in(3'b111, s);
    settle(1);
    `CHK("stop mode", CCL_STOP_MODE, mode)
    `CHK("stop enables", ~s[2:1], {pll_enable, osc_enable})
    set_in(c, s);
    settle(2);
    `CHK("no stop reset", 1'b0, sys_reset_req)
    set_in(c, s & 6'b110111);
    settle(1);
    `CHK("wake mode", m, mode)
    apb(1'b0, CCL_STAT_OFF, 32'h0);
    `CHK("wake status", st, rdv)
    set_in(3'b111, 6'h00);
    settle(1);
    `CHK("recovering mode", m2, mode)
    settle(1);
    `CHK("normal again", CCL_NORMAL_PLL_MODE, mode)
    apb(1'b1, CCL_CTRL_OFF, 32'h2100);
  endtask

  task automatic t_stop();
    stop_case(6'b001110, 3'b000, CCL_SELF_CLOCKED_MODE, 32'h20, CCL_RELOCK_MODE);
    stop_case(6'b001100, 3'b100, CCL_RELOCK_MODE, 32'h40, CCL_NORMAL_PLL_MODE);
    stop_case(6'b001101, 3'b110, CCL_NORMAL_PLL_MODE, 32'h00, CCL_NORMAL_PLL_MODE);
    stop_case(6'b001000, 3'b011, CCL_SELF_CLOCKED_MODE, 32'h24, CCL_RELOCK_MODE);
    stop_case(6'b001000, 3'b100, CCL_REFERENCE_MODE, 32'h14, CCL_NORMAL_PLL_MODE);
  endtask

  // pll-off stop with loss reset left enabled raises the reset request
  task automatic t_stop_rst();
    apb(1'b1, CCL_CTRL_OFF, 32'h2980);
    set_in(3'b111, 6'b001100);
    settle(2);
    `CHK("pll-off stop reset", 1'b1, sys_reset_req)
    apb(1'b1, CCL_CTRL_OFF, 32'h2180);
    settle(1);
    `CHK("stop reset cleared", 1'b0, sys_reset_req)
    set_in(3'b111, 6'h00);
    settle(1);
    `CHK("pll-off relock", CCL_RELOCK_MODE, mode)
    settle(1);
    `CHK("pll-off normal", CCL_NORMAL_PLL_MODE, mode)
    apb(1'b1, CCL_CTRL_OFF, 32'h2100);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_mult();
    t_div();
    t_loss();
    t_stop();
    t_stop_rst();
    conclude();
  end
endmodule
